// ==== pkg/pci_pkg.sv ====
// Shared constants and carriers for the pin-change interrupt unit.
// Assumes one system clock and a plain register port, indices 0..4.
package pci_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LOW_W = 8;
  localparam int unsigned MID_W = 3;
  localparam int unsigned HIGH_W = 8;
  localparam int unsigned PIN_W = 19;
  localparam int unsigned GRP_W = 3;

  // ----------------------------------------------------------------
  // Register indices and bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_GROUP_ENABLE = 3'h0;
  localparam logic [2:0] OFF_GROUP_FLAGS = 3'h1;
  localparam logic [2:0] OFF_MASK_LOW = 3'h2;
  localparam logic [2:0] OFF_MASK_MID = 3'h3;
  localparam logic [2:0] OFF_MASK_HIGH = 3'h4;
  localparam int unsigned BIT_HIGH = 2;
  localparam int unsigned BIT_MID = 1;
  localparam int unsigned BIT_LOW = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_GROUP = 3'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_MID = 3'h0;
  localparam logic [4:0] RESERVED_ZERO = 5'h00;
  localparam logic [1:0] PRIME_LAST = 2'h3;
  localparam logic [1:0] PRIME_FIRST = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    PCI_ST_PRIME = 1'b0,
    PCI_ST_RUN = 1'b1
  } pci_state_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pci_bus_req_s;

  typedef struct packed {
    logic [7:0] high;
    logic [2:0] mid;
    logic [7:0] low;
  } pci_pins_s;

endpackage : pci_pkg

// ==== design/pci_sync.sv ====
// Two-stage synchroniser for the port pin levels.
// Assumes the inputs are asynchronous to clock.
`timescale 1ns/1ps
module pci_sync #(
  parameter int unsigned WIDTH = 19
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] level;
  } pci_sync_s;

  pci_sync_s st_q;
  pci_sync_s st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d.meta = async_in;
    st_d.level = st_q.meta;
  end

  // Synchronous reset to a quiet level
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.level;

endmodule : pci_sync

// ==== design/pci_detect.sv ====
// Change detector for one pin group: masked toggles ORed to one hit.
// Assumes levels are already synchronised to clock.
`timescale 1ns/1ps
module pci_detect #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] mask,
  input wire logic group_enable,
  input wire logic arm,
  output logic hit
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } pci_det_s;

  pci_det_s st_q;
  pci_det_s st_d;
  logic [WIDTH-1:0] toggled;

  // Per-pin toggle gated by its own mask bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    assign toggled[i] = (level[i] ^ st_q.prev[i]) & mask[i]; // RL14 RL17
  end

  // Previous level follows every cycle, armed or not
  always_comb begin
    st_d.prev = level;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hit = (|toggled) & group_enable & arm;

endmodule : pci_detect

// ==== design/pci_top.sv ====
// Pin-change interrupt unit: three pin groups, masks, enables, flags.
// Assumes a single-clock register port and a core that pulses
// vector_service when it starts a group's routine.
//
// Function
// RL1: High group change requests high vector when enabled.
// RL2: Mid group change requests mid vector when enabled.
// RL3: Low group change requests low vector when enabled.
// RL4: Unused upper bits read as zero.
// RL5: High group change sets high flag.
// RL6: Mid group change sets mid flag.
// RL7: Low group change sets low flag.
// RL8: Vector requested only with flag, enable, global.
// RL9: Starting a vector routine clears its flag.
// RL10: Writing one clears flag; zero keeps.
// RL11: Low mask bits gate pins, with enable.
// RL12: Mid mask bits gate pins, with enable.
// RL13: High mask bits gate pins, with enable.
// RL14: Masked-off pins never set flags.
// RL15: Detection keeps working without any I/O clock; here pins are sampled on clock, so detection stops when clock stops.
// RL16: Pins driven as outputs still raise changes.
// RL17: Compare synchronised level to previous, OR masked.
`timescale 1ns/1ps
module pci_top (
  input wire logic clock,
  input wire logic rst,
  input wire pci_pkg::pci_bus_req_s bus_req,
  output logic [7:0] rdata,
  input wire pci_pkg::pci_pins_s pin_level,
  input wire logic global_irq_enable,
  input wire logic [2:0] vector_service,
  output logic [2:0] vector_request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] group_enable;
    logic [2:0] group_flags;
    logic [7:0] low_group_mask;
    logic [2:0] mid_group_mask;
    logic [7:0] high_group_mask;
    logic [2:0] request;
    logic [7:0] rdata;
    pci_pkg::pci_state_e state;
    logic [1:0] prime_cnt;
  } pci_top_s;

  pci_top_s st_q;
  pci_top_s st_d;
  pci_pkg::pci_pins_s pin_sync;
  logic [2:0] hit;
  logic [2:0] flag_clr;
  logic arm;

  // ----------------------------------------------------------------
  // Pin sampling and change detection
  // ----------------------------------------------------------------
  // Pins are sampled at the pad, whatever their direction
  pci_sync #(
    .WIDTH(pci_pkg::PIN_W)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(pin_level), // RL16
    .sync_out(pin_sync)
  );

  // Detection is only armed once the sync stages hold real levels
  assign arm = (st_q.state == pci_pkg::PCI_ST_RUN);

  pci_detect #(
    .WIDTH(pci_pkg::LOW_W)
  ) u_det_low (
    .clock(clock),
    .rst(rst),
    .level(pin_sync.low),
    .mask(st_q.low_group_mask), // RL11
    .group_enable(st_q.group_enable[pci_pkg::BIT_LOW]),
    .arm(arm),
    .hit(hit[pci_pkg::BIT_LOW])
  );

  pci_detect #(
    .WIDTH(pci_pkg::MID_W)
  ) u_det_mid (
    .clock(clock),
    .rst(rst),
    .level(pin_sync.mid),
    .mask(st_q.mid_group_mask), // RL12
    .group_enable(st_q.group_enable[pci_pkg::BIT_MID]),
    .arm(arm),
    .hit(hit[pci_pkg::BIT_MID])
  );

  pci_detect #(
    .WIDTH(pci_pkg::HIGH_W)
  ) u_det_high (
    .clock(clock),
    .rst(rst),
    .level(pin_sync.high),
    .mask(st_q.high_group_mask), // RL13
    .group_enable(st_q.group_enable[pci_pkg::BIT_HIGH]),
    .arm(arm),
    .hit(hit[pci_pkg::BIT_HIGH])
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Flag clears from a one written to the flag register or service
  always_comb begin
    flag_clr = vector_service; // RL9
    if (bus_req.wr && bus_req.addr == pci_pkg::OFF_GROUP_FLAGS) begin
      flag_clr = flag_clr | bus_req.wdata[2:0]; // RL10
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.rdata = pci_pkg::RST_BYTE;
    // Priming: wait out the sync pipeline after reset
    case (st_q.state)
      pci_pkg::PCI_ST_PRIME: begin
        st_d.prime_cnt = st_q.prime_cnt + 2'h1;
        if (st_q.prime_cnt == pci_pkg::PRIME_LAST) begin
          st_d.state = pci_pkg::PCI_ST_RUN;
        end
      end
      pci_pkg::PCI_ST_RUN: begin
        st_d.prime_cnt = st_q.prime_cnt;
      end
      default: begin
        st_d.state = pci_pkg::PCI_ST_PRIME;
      end
    endcase
    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        pci_pkg::OFF_GROUP_ENABLE: begin
          st_d.group_enable = bus_req.wdata[2:0];
        end
        pci_pkg::OFF_MASK_LOW: begin
          st_d.low_group_mask = bus_req.wdata;
        end
        pci_pkg::OFF_MASK_MID: begin
          st_d.mid_group_mask = bus_req.wdata[2:0];
        end
        pci_pkg::OFF_MASK_HIGH: begin
          st_d.high_group_mask = bus_req.wdata;
        end
        default: begin
          st_d.group_enable = st_q.group_enable;
        end
      endcase
    end
    // Set beats clear so a change in the clearing cycle is kept
    st_d.group_flags = (st_q.group_flags & ~flag_clr) | hit; // RL5 RL6 RL7
    // Request follows the new flag, enable and global flag
    st_d.request = st_d.group_flags & st_d.group_enable
      & {pci_pkg::GRP_W{global_irq_enable}}; // RL1 RL2 RL3 RL8
    // Register reads, data valid the cycle after the strobe
    if (bus_req.rd) begin
      case (bus_req.addr)
        pci_pkg::OFF_GROUP_ENABLE: begin
          st_d.rdata = {pci_pkg::RESERVED_ZERO, st_q.group_enable}; // RL4
        end
        pci_pkg::OFF_GROUP_FLAGS: begin
          st_d.rdata = {pci_pkg::RESERVED_ZERO, st_q.group_flags}; // RL4
        end
        pci_pkg::OFF_MASK_LOW: begin
          st_d.rdata = st_q.low_group_mask;
        end
        pci_pkg::OFF_MASK_MID: begin
          st_d.rdata = {pci_pkg::RESERVED_ZERO, st_q.mid_group_mask}; // RL4
        end
        pci_pkg::OFF_MASK_HIGH: begin
          st_d.rdata = st_q.high_group_mask;
        end
        default: begin
          st_d.rdata = pci_pkg::RST_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Sampled detection trades wake-from-sleep for a clean single clock
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q.group_enable <= pci_pkg::RST_GROUP;
      st_q.group_flags <= pci_pkg::RST_GROUP;
      st_q.low_group_mask <= pci_pkg::RST_BYTE;
      st_q.mid_group_mask <= pci_pkg::RST_MID;
      st_q.high_group_mask <= pci_pkg::RST_BYTE;
      st_q.request <= pci_pkg::RST_GROUP;
      st_q.rdata <= pci_pkg::RST_BYTE;
      st_q.state <= pci_pkg::PCI_ST_PRIME;
      st_q.prime_cnt <= pci_pkg::PRIME_FIRST;
    end else begin
      st_q <= st_d; // RL15
    end
  end

  assign rdata = st_q.rdata;
  assign vector_request = st_q.request;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  high_request_a: assert property (@(posedge clock) disable iff (rst) // RL1
    !$past(rst) |-> vector_request[2] ==
      (st_q.group_flags[2] && st_q.group_enable[2] && $past(global_irq_enable)))
    else $error("high vector request mismatch");

  mid_request_a: assert property (@(posedge clock) disable iff (rst) // RL2
    !$past(rst) |-> vector_request[1] ==
      (st_q.group_flags[1] && st_q.group_enable[1] && $past(global_irq_enable)))
    else $error("mid vector request mismatch");

  low_request_a: assert property (@(posedge clock) disable iff (rst) // RL3
    !$past(rst) |-> vector_request[0] ==
      (st_q.group_flags[0] && st_q.group_enable[0] && $past(global_irq_enable)))
    else $error("low vector request mismatch");

  reserved_zero_a: assert property (@(posedge clock) disable iff (rst) // RL4
    bus_req.rd && (bus_req.addr == pci_pkg::OFF_GROUP_ENABLE
      || bus_req.addr == pci_pkg::OFF_GROUP_FLAGS
      || bus_req.addr == pci_pkg::OFF_MASK_MID)
    |=> rdata[7:3] == 5'h00 && (rdata[2:0] == $past(st_q.group_flags)
      || $past(bus_req.addr) != pci_pkg::OFF_GROUP_FLAGS))
    else $error("reserved bits read nonzero");

  high_flag_set_a: assert property (@(posedge clock) disable iff (rst) // RL5
    hit[2] |=> st_q.group_flags[2])
    else $error("high flag not set on change");

  mid_flag_set_a: assert property (@(posedge clock) disable iff (rst) // RL6
    hit[1] |=> st_q.group_flags[1])
    else $error("mid flag not set on change");

  low_flag_set_a: assert property (@(posedge clock) disable iff (rst) // RL7
    hit[0] |=> st_q.group_flags[0])
    else $error("low flag not set on change");

  no_global_a: assert property (@(posedge clock) disable iff (rst) // RL8
    !global_irq_enable |=> vector_request == 3'h0)
    else $error("request without global flag");

  service_clear_a: assert property (@(posedge clock) disable iff (rst) // RL9
    vector_service[0] && !hit[0] |=> !st_q.group_flags[0])
    else $error("service did not clear flag");

  write_keep_a: assert property (@(posedge clock) disable iff (rst) // RL10
    bus_req.wr && bus_req.addr == pci_pkg::OFF_GROUP_FLAGS
      && !bus_req.wdata[0] && !vector_service[0] && st_q.group_flags[0]
    |=> st_q.group_flags[0])
    else $error("zero write altered flag");

  write_clear_a: assert property (@(posedge clock) disable iff (rst) // RL10
    bus_req.wr && bus_req.addr == pci_pkg::OFF_GROUP_FLAGS
      && bus_req.wdata[0] && !hit[0]
    |=> !st_q.group_flags[0])
    else $error("one write did not clear flag");

  low_gate_a: assert property (@(posedge clock) disable iff (rst) // RL11
    !st_q.group_enable[0] && !st_q.group_flags[0] |=> !st_q.group_flags[0])
    else $error("disabled low group set flag");

  mid_gate_a: assert property (@(posedge clock) disable iff (rst) // RL12
    !st_q.group_enable[1] && !st_q.group_flags[1] |=> !st_q.group_flags[1])
    else $error("disabled mid group set flag");

  high_mask_a: assert property (@(posedge clock) disable iff (rst) // RL14
    st_q.high_group_mask == 8'h00 && !st_q.group_flags[2]
    |=> !st_q.group_flags[2])
    else $error("masked high pins set flag");

  pin_change_a: assert property (@(posedge clock) disable iff (rst) // RL17
    arm && st_q.group_enable[0] && st_q.low_group_mask[0]
      && $changed(pin_sync.low[0])
    |=> st_q.group_flags[0])
    else $error("masked change missed");

  high_gate_a: assert property (@(posedge clock) disable iff (rst) // RL13
    !st_q.group_enable[2]
      && !st_q.group_flags[2]
    |=> !st_q.group_flags[2])
    else $error("disabled high group set flag");

  low_mask_a: assert property (@(posedge clock) disable iff (rst) // RL14
    st_q.low_group_mask == 8'h00
      && !st_q.group_flags[0]
    |=> !st_q.group_flags[0])
    else $error("masked low pins set flag");

  mid_mask_a: assert property (@(posedge clock) disable iff (rst) // RL14
    st_q.mid_group_mask == 3'h0
      && !st_q.group_flags[1]
    |=> !st_q.group_flags[1])
    else $error("masked mid pins set flag");

  mid_service_a: assert property (@(posedge clock) disable iff (rst) // RL9
    vector_service[1]
      && !hit[1]
    |=> !st_q.group_flags[1])
    else $error("service did not clear mid flag");

  high_service_a: assert property (@(posedge clock) disable iff (rst) // RL9
    vector_service[2]
      && !hit[2]
    |=> !st_q.group_flags[2])
    else $error("service did not clear high flag");

  one_write_all_a: assert property (@(posedge clock) disable iff (rst) // RL10
    bus_req.wr && bus_req.addr == pci_pkg::OFF_GROUP_FLAGS
    |=> (st_q.group_flags & $past(bus_req.wdata[2:0]) & ~$past(hit))
      == 3'h0)
    else $error("one write left a flag set");

  low_source_a: assert property (@(posedge clock) disable iff (rst) // RL7
    !st_q.group_flags[0]
      && !hit[0]
    |=> !st_q.group_flags[0])
    else $error("low flag set without change");

  mid_source_a: assert property (@(posedge clock) disable iff (rst) // RL6
    !st_q.group_flags[1]
      && !hit[1]
    |=> !st_q.group_flags[1])
    else $error("mid flag set without change");

  high_source_a: assert property (@(posedge clock) disable iff (rst) // RL5
    !st_q.group_flags[2]
      && !hit[2]
    |=> !st_q.group_flags[2])
    else $error("high flag set without change");

  low_mask_read_a: assert property (@(posedge clock) disable iff (rst) // RL11
    bus_req.rd
      && bus_req.addr == pci_pkg::OFF_MASK_LOW
    |=> rdata == $past(st_q.low_group_mask))
    else $error("low mask read back wrong");

  read_window_a: assert property (@(posedge clock) disable iff (rst)
    !bus_req.rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");

endmodule : pci_top

// ==== verif/pci_pin_model.sv ====
// Behavioural model of the pads that feed the three pin groups.
// Assumes the bench asks for pin flips by a one-cycle pulse on toggle.
`timescale 1ns/1ps
module pci_pin_model (
  input wire logic clock,
  input wire logic [18:0] toggle,
  output pci_pkg::pci_pins_s pins
);
  // ----------------------------------------------------------------
  // Pad levels
  // ----------------------------------------------------------------
  logic [18:0] level_q = 19'h00000;

  // Each flip holds for many cycles, longer than one clock as the sync needs
  always @(posedge clock) begin
    level_q <= level_q ^ toggle;
  end

  // Packed order is high, mid, low: low pins 0..7, mid 8..10, high 11..18
  assign pins = level_q;
endmodule : pci_pin_model

// ==== verif/tb_pin_change_interrupt_unit.sv ====
// Self-checking bench for the pin-change interrupt unit.
// Assumes the pad model drives the pins and the bench plays the core.
`timescale 1ns/1ps
module tb_pin_change_interrupt_unit;
  logic clock = 1'b0;
  logic rst = 1'b1;
  pci_pkg::pci_bus_req_s bus_req = '0;
  logic [7:0] rdata;
  pci_pkg::pci_pins_s pin_level;
  logic global_irq_enable = 1'b0;
  logic [2:0] vector_service = 3'h0;
  logic [2:0] vector_request;
  logic [18:0] toggle = 19'h00000;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;

  always #10 clock = ~clock;

  pci_top dut (.clock(clock), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .pin_level(pin_level), .global_irq_enable(global_irq_enable),
    .vector_service(vector_service), .vector_request(vector_request));
  pci_pin_model pads (.clock(clock), .toggle(toggle), .pins(pin_level));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    num_checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe, so look there
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_chk

  task automatic req_chk(input logic [2:0] exp);
    #1 check({5'h00, vector_request}, {5'h00, exp});
  endtask : req_chk

  // Flag needs 3..4 cycles after the pad moves; 6 leaves margin
  task automatic flip(input int idx);
    @(posedge clock);
    toggle <= 19'h00001 << idx;
    @(posedge clock);
    toggle <= 19'h00000;
    repeat (6) @(posedge clock);
  endtask : flip

  task automatic serve(input int g);
    @(posedge clock);
    vector_service <= 3'h1 << g;
    @(posedge clock);
    vector_service <= 3'h0;
    repeat (2) @(posedge clock);
  endtask : serve

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    for (int a = 0; a < 8; a++) begin
      rd_chk(a[2:0], 8'h00);
    end
    for (int a = 0; a < 6; a++) begin
      wr(a[2:0], 8'hff);
    end
    rd_chk(pci_pkg::OFF_GROUP_ENABLE, 8'h07);
    rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h00);
    rd_chk(pci_pkg::OFF_MASK_LOW, 8'hff);
    rd_chk(pci_pkg::OFF_MASK_MID, 8'h07);
    rd_chk(pci_pkg::OFF_MASK_HIGH, 8'hff);
    rd_chk(3'h5, 8'h00);
    for (int a = 0; a < 5; a++) begin
      wr(a[2:0], 8'h00);
    end
    $display("test regs done");
  endtask : test_regs

  // Top pin of each group, so the group boundary is exercised
  task automatic test_groups();
    logic [2:0] moff [3] = '{pci_pkg::OFF_MASK_LOW, pci_pkg::OFF_MASK_MID,
      pci_pkg::OFF_MASK_HIGH};
    logic [7:0] mval [3] = '{8'h80, 8'h04, 8'h80};
    int top [3] = '{7, 10, 18};
    global_irq_enable <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      wr(pci_pkg::OFF_GROUP_ENABLE, 8'h01 << g);
      wr(moff[g], mval[g]);
      flip(top[g]);
      req_chk(3'h1 << g);
      rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h01 << g);
      serve(g);
      rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h00);
      req_chk(3'h0);
      wr(moff[g], 8'h00);
    end
    $display("test groups done");
  endtask : test_groups

  // Masked pins and disabled groups leave no trace, even when enabled later
  task automatic test_mask();
    wr(pci_pkg::OFF_GROUP_ENABLE, 8'h01);
    wr(pci_pkg::OFF_MASK_LOW, 8'hfe);
    flip(0);
    rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h00);
    wr(pci_pkg::OFF_GROUP_ENABLE, 8'h00);
    wr(pci_pkg::OFF_MASK_HIGH, 8'hff);
    flip(11);
    wr(pci_pkg::OFF_GROUP_ENABLE, 8'h04);
    rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h00);
    wr(pci_pkg::OFF_MASK_HIGH, 8'h00);
    wr(pci_pkg::OFF_GROUP_ENABLE, 8'h02);
    flip(8);
    rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h00);
    req_chk(3'h0);
    $display("test mask done");
  endtask : test_mask

  task automatic test_clear();
    global_irq_enable <= 1'b0;
    wr(pci_pkg::OFF_GROUP_ENABLE, 8'h01);
    wr(pci_pkg::OFF_MASK_LOW, 8'h01);
    flip(0);
    rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h01);
    req_chk(3'h0);
    @(posedge clock);
    global_irq_enable <= 1'b1;
    repeat (2) @(posedge clock);
    req_chk(3'h1);
    wr(pci_pkg::OFF_GROUP_ENABLE, 8'h00);
    req_chk(3'h0);
    wr(pci_pkg::OFF_GROUP_FLAGS, 8'h06);
    rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h01);
    wr(pci_pkg::OFF_GROUP_FLAGS, 8'h01);
    rd_chk(pci_pkg::OFF_GROUP_FLAGS, 8'h00);
    $display("test clear done");
  endtask : test_clear

  // ----------------------------------------------------------------
  // Closing and main sequence
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run needs well under a thousand cycles; the ceiling cuts a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Priming after reset ignores pins, so wait it out before pad activity
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    test_regs();
    test_groups();
    test_mask();
    test_clear();
    tally_and_finish();
  end
endmodule : tb_pin_change_interrupt_unit
